// [rtl/tmac_top.sv]
`timescale 1ns/1ns
`include "tmac_map.svh"

module tmac_top
    import tmac_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire tmac_count_t timer_count_value,
    input  wire logic        count_enable_bit,
    input  wire logic [2:0]  interrupt_mode_select,
    output logic             counter_halt,
    output logic             count_enable_clear,
    output logic             counter_reset,
    output logic             match_irq_pulse,
    output logic      [2:0]  match_irq_mode,
    output logic             irq
);
    localparam int NCH = `TMAC_NCHAN;

    tmac_top_s        r;
    tmac_top_s        next_r;
    logic [NCH-1:0]   ch_halt;
    logic [NCH-1:0]   ch_crst;
    logic [NCH-1:0]   ch_irq;
    logic             wr;
    logic             setup;
    logic [31:0]      rd_val;
    logic             rd_bad;

    tmac_chan_if cif [NCH] ();

    // one comparator per channel; action enables come straight from the control word, the count enable from count_enable_bit
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            assign cif[gi].match_val = r.match[gi];
            assign cif[gi].count_val = timer_count_value;
            assign cif[gi].count_en  = count_enable_bit;
            assign cif[gi].halt_en   = r.ctrl[`TMAC_HALT_BIT0 + 3*gi];
            assign cif[gi].rst_en    = r.ctrl[`TMAC_RST_BIT0 + 3*gi];
            assign cif[gi].irq_en    = r.ctrl[`TMAC_IRQ_BIT0 + 3*gi];
            assign ch_halt[gi]       = cif[gi].halt;
            assign ch_crst[gi]       = cif[gi].crst;
            assign ch_irq[gi]        = cif[gi].irq;

            tmac_match_chan u_chan (
                .pclk    (pclk),
                .presetn (presetn),
                .ch      (cif[gi])
            );
        end
    endgenerate

    // apb phases: a write lands at the access edge, read data is
    // captured in setup so it comes from a flop during access
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite;

    // read mux, also flags unmapped offsets
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_bad = 1'b0;
        case (paddr)
            `TMAC_OFS_CTRL:   rd_val = r.ctrl;
            `TMAC_OFS_MATCH2: rd_val = {16'h0000, r.match[0]};
            `TMAC_OFS_MATCH3: rd_val = {16'h0000, r.match[1]};
            `TMAC_OFS_MATCH4: rd_val = {16'h0000, r.match[2]};
            `TMAC_OFS_MATCH5: rd_val = {16'h0000, r.match[3]};
            `TMAC_OFS_STATUS: rd_val = {28'h000_0000, r.status};
            `TMAC_OFS_MASK:   rd_val = {28'h000_0000, r.mask};
            default:          rd_bad = 1'b1;
        endcase
    end

    // next state: register writes, event flags and action pulses
    always_comb begin
        next_r = r;
        if (setup) begin
            next_r.prdata = pwrite ? 32'h0000_0000 : rd_val;
            next_r.bad    = rd_bad;
        end
        if (wr) begin
            case (paddr)
                `TMAC_OFS_CTRL:   next_r.ctrl = pwdata & `TMAC_CTRL_WMASK;
                `TMAC_OFS_MATCH2: next_r.match[0] = pwdata[`TMAC_COUNT_W-1:0];
                `TMAC_OFS_MATCH3: next_r.match[1] = pwdata[`TMAC_COUNT_W-1:0];
                `TMAC_OFS_MATCH4: next_r.match[2] = pwdata[`TMAC_COUNT_W-1:0];
                `TMAC_OFS_MATCH5: next_r.match[3] = pwdata[`TMAC_COUNT_W-1:0];
                `TMAC_OFS_STATUS: next_r.status = r.status & ~pwdata[NCH-1:0];
                `TMAC_OFS_MASK:   next_r.mask = pwdata[NCH-1:0];
                default:          next_r.bad = r.bad;
            endcase
        end
        // set after clear so a match in the clearing cycle is kept
        next_r.status    = next_r.status | ch_irq;
        // halt from any channel stops the counter and drops the count enable together
        next_r.halt      = |ch_halt;
        next_r.en_clr    = |ch_halt;
        next_r.crst      = |ch_crst;
        next_r.irq_pulse = |ch_irq;
        // the mode field is carried with the request; the interrupt
        // generator outside decides what each mode does with it
        next_r.irq_mode  = (|ch_irq) ? interrupt_mode_select : r.irq_mode;
    end

    // all settings and flags clear to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // single-wait-free slave: access phase always completes at once
    assign pready             = 1'b1;
    assign pslverr            = psel & penable & r.bad;
    assign prdata             = r.prdata;
    assign counter_halt       = r.halt;
    assign count_enable_clear = r.en_clr;
    assign counter_reset      = r.crst;
    assign match_irq_pulse    = r.irq_pulse;
    assign match_irq_mode     = r.irq_mode;
    assign irq                = |(r.status & r.mask);
endmodule

// [rtl/tmac_map.svh]
`ifndef TMAC_MAP_SVH
`define TMAC_MAP_SVH

// counter width, channel count and number of the first match channel
`define TMAC_COUNT_W       16
`define TMAC_NCHAN         4
`define TMAC_FIRST_CHAN    2

// register byte offsets
`define TMAC_OFS_CTRL      8'h00
`define TMAC_OFS_MATCH2    8'h04
`define TMAC_OFS_MATCH3    8'h08
`define TMAC_OFS_MATCH4    8'h0C
`define TMAC_OFS_MATCH5    8'h10
`define TMAC_OFS_STATUS    8'h14
`define TMAC_OFS_MASK      8'h18

// control field positions: channel i (0 = match2) sits at base + 3*i
`define TMAC_IRQ_BIT0      6
`define TMAC_RST_BIT0      7
`define TMAC_HALT_BIT0     8
// writable control bits: 7 (match2 reset) up to 16 (match5 reset)
`define TMAC_CTRL_WMASK    32'h0001_FF80

// reset values
`define TMAC_CTRL_RST      32'h0000_0000
`define TMAC_MATCH_RST     16'h0000
`define TMAC_STATUS_RST    4'h0
`define TMAC_MASK_RST      4'h0

`endif

// [rtl/tmac_pkg.sv]
`include "tmac_map.svh"

package tmac_pkg;

    typedef logic [`TMAC_COUNT_W-1:0] tmac_count_t;

    // state of one match channel
    typedef struct packed {
        logic prev_equal;
    } tmac_chan_s;

    // state of the register file and action outputs
    typedef struct packed {
        logic [31:0]                          ctrl;
        logic [`TMAC_NCHAN-1:0][`TMAC_COUNT_W-1:0] match;
        logic [`TMAC_NCHAN-1:0]               status;
        logic [`TMAC_NCHAN-1:0]               mask;
        logic [31:0]                          prdata;
        logic                                 bad;
        logic                                 halt;
        logic                                 en_clr;
        logic                                 crst;
        logic                                 irq_pulse;
        logic [2:0]                           irq_mode;
    } tmac_top_s;

endpackage

// [rtl/tmac_chan_if.sv]
`timescale 1ns/1ns
`include "tmac_map.svh"

interface tmac_chan_if;
    import tmac_pkg::*;

    tmac_count_t match_val;
    tmac_count_t count_val;
    logic        count_en;
    logic        halt_en;
    logic        rst_en;
    logic        irq_en;
    logic        halt;
    logic        crst;
    logic        irq;

    modport chan (
        input  match_val, count_val, count_en, halt_en, rst_en, irq_en,
        output halt, crst, irq
    );
    modport ctl (
        output match_val, count_val, count_en, halt_en, rst_en, irq_en,
        input  halt, crst, irq
    );
endinterface

// [rtl/tmac_match_chan.sv]
`timescale 1ns/1ns
`include "tmac_map.svh"

module tmac_match_chan
    import tmac_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    tmac_chan_if.chan   ch
);
    tmac_chan_s r;
    tmac_chan_s next_r;
    logic       equal;
    logic       hit;

    // one event per arrival at the match value, so a counter parked
    // on the match value does not fire again every cycle
    assign equal = (ch.match_val == ch.count_val);
    assign hit   = ch.count_en & equal & ~r.prev_equal;

    // stop takes precedence: reset is suppressed when both are set
    assign ch.halt = hit & ch.halt_en;
    assign ch.crst = hit & ch.rst_en & ~ch.halt_en;
    assign ch.irq  = hit & ch.irq_en;

    always_comb begin
        next_r            = r;
        next_r.prev_equal = equal & ch.count_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

// [bench/tmac_top_sva.sv]
`timescale 1ns/1ns
module tmac_top_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       count_enable_bit,
    input wire logic [2:0] interrupt_mode_select,
    input wire logic       counter_halt,
    input wire logic       count_enable_clear,
    input wire logic       counter_reset,
    input wire logic       match_irq_pulse,
    input wire logic [2:0] match_irq_mode
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access; psel && penable; endsequence
    // a match counts only while running; pulses come one edge later
    sequence s_ran; $past(count_enable_bit); endsequence
    AST_ERR_PHASE: assert property (pslverr |-> s_access) else $error("stray error");
    AST_READY: assert property (s_access |-> pready) else $error("wait state");
    AST_HALT_CLR: assert property (counter_halt == count_enable_clear) else $error("halt split");
    AST_HALT_RAN: assert property (counter_halt |-> s_ran) else $error("halt idle");
    AST_RST_RAN: assert property (counter_reset |-> s_ran) else $error("reset idle");
    AST_IRQ_RAN: assert property (match_irq_pulse |-> s_ran) else $error("irq idle");
    AST_IRQ_MODE: assert property (match_irq_pulse |-> match_irq_mode == $past(interrupt_mode_select))
        else $error("mode wrong");
    AST_MODE_HOLD: assert property (!match_irq_pulse |-> $stable(match_irq_mode)) else $error("mode moved");
endmodule

bind tmac_top tmac_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .count_enable_bit,
    .interrupt_mode_select, .counter_halt, .count_enable_clear, .counter_reset, .match_irq_pulse, .match_irq_mode);

// [bench/timer_match_action_control_test.sv]
`timescale 1ns/1ns
`include "tmac_map.svh"
module timer_match_action_control_test import tmac_pkg::*;;
    logic        pclk = 1'h0;
    logic        presetn, psel, penable, pwrite, run;
    logic        halt, cclr, crst, ipul, irq, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, d, v;
    logic [2:0]  mode, imode, lm;
    tmac_count_t cnt, m;
    int          fails, comparisons, st, mk, g, hb, rb, ib, hold;
    logic [6:0]  act_q[$];

    tmac_top u_tmac_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .timer_count_value(cnt), .count_enable_bit(run), .interrupt_mode_select(mode), .counter_halt(halt),
        .count_enable_clear(cclr), .counter_reset(crst), .match_irq_pulse(ipul), .match_irq_mode(imode), .irq);

    // 20 ns period
    always #10 pclk = ~pclk;

    // one bookkeeping point shared by every compare
    task automatic tally(input bit ok, input string what);
        comparisons++;
        if (!ok) begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    // register read data and error flag against the bench's copy
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tally(got === exp, $sformatf("register %h want %h", got, exp));
    endtask

    // action pulses and captured mode against the model's queue
    task automatic chk_act(input logic [6:0] got);
        logic [6:0] exp;
        exp = act_q.pop_front();
        tally(got === exp, $sformatf("actions %b want %b", got, exp));
    endtask

    // interrupt level against the model's status and mask
    task automatic chk_irq(input logic got, input logic exp);
        tally(got === exp, $sformatf("irq %b want %b", got, exp));
    endtask

    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0000_0000);
        chk_reg(rd, e);
        chk_reg({31'h0000_0000, er}, 32'h0000_0000);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, run, paddr, pwdata, cnt, mode} = '0;
        {fails, comparisons, st, mk, lm} = '0;
        void'($urandom(32'hcaa5_95e2));
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 0; a <= 24; a += 4) rc(8'(a), 32'h0000_0000);
        apb(1'h0, 8'h1c, 32'h0000_0000);
        chk_reg({rd[30:0], er}, 32'h0000_0001);
        d = $urandom;
        apb(1'h1, `TMAC_OFS_CTRL, d);
        rc(`TMAC_OFS_CTRL, d & `TMAC_CTRL_WMASK);
        mk = $urandom % 16;
        apb(1'h1, `TMAC_OFS_MASK, 32'(mk));
        // every channel, every mix of writable settings, counter running or not
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 16; k++) begin
                m = 16'(1 + $urandom % 65533);
                apb(1'h1, 8'(`TMAC_OFS_MATCH2 + 4 * c), 32'(m));
                d = 32'(k % 8) << (6 + 3 * c) & `TMAC_CTRL_WMASK;
                apb(1'h1, `TMAC_OFS_CTRL, d);
                @(posedge pclk);
                cnt <= m;
                run <= 1'(k / 8);
                mode <= 3'($urandom);
                hold = $urandom % 2;
                @(posedge pclk);
                // a count parked on the match value must not fire a second time
                if (hold == 0) begin
                    cnt <= 16'h0000;
                    run <= 1'h0;
                end
                #1;
                g = k / 8;
                hb = g & d[8 + 3 * c];
                rb = g & d[7 + 3 * c] & !hb;
                ib = g & d[6 + 3 * c];
                if (ib) lm = mode;
                if (ib) st |= 1 << c;
                act_q.push_back({hb[0], hb[0], rb[0], ib[0], lm});
                chk_act({halt, cclr, crst, ipul, imode});
                @(posedge pclk);
                cnt <= 16'h0000;
                run <= 1'h0;
                #1;
                act_q.push_back({4'h0, lm});
                chk_act({halt, cclr, crst, ipul, imode});
                rc(`TMAC_OFS_STATUS, 32'(st));
                chk_irq(irq, (st & mk) != 0);
                v = $urandom % 16;
                apb(1'h1, `TMAC_OFS_STATUS, v);
                st &= ~int'(v);
            end
        end
        // a match in the very cycle of a clearing write keeps its status bit
        apb(1'h1, `TMAC_OFS_CTRL, 32'h0000_0200);
        apb(1'h1, `TMAC_OFS_MATCH3, 32'(m));
        fork
            apb(1'h1, `TMAC_OFS_STATUS, 32'h0000_000F);
            begin
                repeat (2) @(posedge pclk);
                cnt <= m;
                run <= 1'h1;
                @(posedge pclk);
                cnt <= 16'h0000;
                run <= 1'h0;
            end
        join
        st = 2;
        rc(`TMAC_OFS_STATUS, 32'(st));
        chk_irq(irq, (st & mk) != 0);
        close_out();
    end

    // about a thousand cycles are needed; this cuts a hang short
    initial begin
        #200_000;
        fails++;
        close_out();
    end
endmodule
